// ### core/ubr_pkg.sv
// Constants, register map and carrier types of the UART baud and error block.
// Assumes a single 100 MHz system clock and an APB master with 32-bit data.
// How it works
// - The bit rate is the operation clock divided by (divider + 1) and by 2.
// - The mode register clock-source bit picks the low or high prescaler field.
// - A prescaler field value p gives the system clock divided by 2 to the p.
// - After a start bit, sample points follow the divider; stop bit checked.
// - Reading the data register clears the buffer-full flag.
// - Ones written to the flag-clear register clear parity/framing/overrun.
// - A one in the stop register clears the enable status and halts receive.
// - A one in the start register sets the enable status and lets it run.
package ubr_pkg;
  localparam logic [11:0] UBR_DATA_OFS = 12'h000;
  localparam logic [11:0] UBR_MODE_OFS = 12'h004;
  localparam logic [11:0] UBR_PRESC_OFS = 12'h008;
  localparam logic [11:0] UBR_STAT_OFS = 12'h00C;
  localparam logic [11:0] UBR_CLR_OFS = 12'h010;
  localparam logic [11:0] UBR_START_OFS = 12'h014;
  localparam logic [11:0] UBR_STOP_OFS = 12'h018;
  localparam logic [11:0] UBR_ENST_OFS = 12'h01C;
  localparam int UBR_DIV_LSB = 9;
  localparam int UBR_CKS_BIT = 15;
  localparam int UBR_PAR_BIT = 0;
  localparam int UBR_BFF_BIT = 6;
  localparam int UBR_PEF_BIT = 1;
  localparam int UBR_FEF_BIT = 2;
  localparam int UBR_OVF_BIT = 0;
  localparam logic [6:0] UBR_DIV_RST = 7'h7F;
  localparam logic [7:0] UBR_PRESC_RST = 8'h00;
  localparam logic [15:0] UBR_MODE_RST = 16'h0000;
  localparam int UBR_DATA_BITS = 8;
  localparam logic [31:0] UBR_BAD_ADDR_DATA = 32'h0000_0000;

  typedef struct packed {
    logic pe;
    logic fe;
    logic ov;
  } ubr_err_t;
endpackage : ubr_pkg

// ### core/ubr_uart_rx.sv
// Baud generation, receiver and error flags of one serial channel.
// Assumes an APB master on clk and an asynchronous serial input pin.
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/10ps
module ubr_uart_rx (
  input wire logic clk, // System clock, 100 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [11:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error, unmapped address.
  input wire logic rxd, // Serial receive pin.
  output ubr_pkg::ubr_err_t err_flags, // Error flags.
  output logic enabled // Channel enable status.
);
  import ubr_pkg::*;

  typedef enum logic [3:0] {
    UBR_IDLE = 4'b0001,
    UBR_START = 4'b0010,
    UBR_DATA = 4'b0100,
    UBR_STOPB = 4'b1000
  } ubr_state_t;

  logic [6:0] div_r;
  logic [7:0] rxdat_r;
  logic [15:0] mode_r;
  logic [7:0] presc_r;
  logic bff_r;
  logic en_r;
  ubr_err_t err_r;
  ubr_state_t st_r;
  logic [14:0] pre_cnt_r;
  logic [14:0] pre_cnt_nxt;
  logic [3:0] p_sel;
  logic mck_tick;
  logic [7:0] bit_cnt_r;
  logic [3:0] nbit_r;
  logic [8:0] shf_r;
  logic [2:0] sync_r;
  logic rx_lvl_r;
  logic rx_prev_r;
  logic par_r;
  logic acc;
  logic wr;
  logic rd;
  logic [7:0] half_cnt;
  logic [7:0] full_cnt;
  logic done;
  logic bad_stop;
  logic bad_par;
  logic setup_rd;
  logic rd_full_r;

  assign acc = psel && penable;
  assign setup_rd = psel && !penable && !pwrite;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign pready = 1'b1;

  always_comb begin
    pslverr = 1'b0;
    if (!acc) begin
      pslverr = 1'b0;
    end else if (paddr == UBR_DATA_OFS || paddr == UBR_MODE_OFS) begin
      pslverr = 1'b0;
    end else if (paddr == UBR_PRESC_OFS || paddr == UBR_STAT_OFS) begin
      pslverr = 1'b0;
    end else if (paddr == UBR_CLR_OFS || paddr == UBR_START_OFS) begin
      pslverr = 1'b0;
    end else if (paddr == UBR_STOP_OFS || paddr == UBR_ENST_OFS) begin
      pslverr = 1'b0;
    end else begin
      pslverr = 1'b1;
    end
  end

  // Read data is loaded in the setup cycle so it stands through the access.
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      rd_full_r <= 1'b0;
    end else if (setup_rd) begin
      if (paddr == UBR_DATA_OFS) begin
        prdata <= {16'h0000, div_r, 1'b0, rxdat_r};
        rd_full_r <= bff_r;
      end else if (paddr == UBR_MODE_OFS) begin
        prdata <= {16'h0000, mode_r};
      end else if (paddr == UBR_PRESC_OFS) begin
        prdata <= {24'h000000, presc_r};
      end else if (paddr == UBR_STAT_OFS) begin
        prdata <= {25'h0, bff_r, 3'h0, err_r.fe, err_r.pe, err_r.ov};
      end else if (paddr == UBR_ENST_OFS) begin
        prdata <= {31'h0, en_r};
      end else begin
        prdata <= UBR_BAD_ADDR_DATA;
      end
    end
  end

  // Configuration writes.
  always_ff @(posedge clk) begin
    if (rst) begin
      div_r <= UBR_DIV_RST;
      mode_r <= UBR_MODE_RST;
      presc_r <= UBR_PRESC_RST;
    end else if (wr) begin
      if (paddr == UBR_DATA_OFS) begin
        div_r <= pwdata[UBR_DIV_LSB +: 7];
      end else if (paddr == UBR_MODE_OFS) begin
        mode_r <= pwdata[15:0];
      end else if (paddr == UBR_PRESC_OFS) begin
        presc_r <= pwdata[7:0];
      end
    end
  end

  // Stop and start sit at separate addresses, so they never collide.
  always_ff @(posedge clk) begin
    if (rst) begin
      en_r <= 1'b0;
    end else if (wr && paddr == UBR_STOP_OFS && pwdata[0]) begin
      en_r <= 1'b0;
    end else if (wr && paddr == UBR_START_OFS && pwdata[0]) begin
      en_r <= 1'b1;
    end
  end
  assign enabled = en_r;

  // Prescaler: free counter, tick when the low p bits are all ones.
  assign p_sel = mode_r[UBR_CKS_BIT] ? presc_r[7:4] : presc_r[3:0];
  assign pre_cnt_nxt = pre_cnt_r + 15'h0001;
  assign mck_tick = ((pre_cnt_r & ((15'h0001 << p_sel) - 15'h0001))
                     == ((15'h0001 << p_sel) - 15'h0001));

  always_ff @(posedge clk) begin
    if (rst) begin
      pre_cnt_r <= 15'h0000;
    end else begin
      pre_cnt_r <= pre_cnt_nxt;
    end
  end

  // Three-stage synchroniser; a change counts when stages two and three agree.
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_r <= 3'b111;
      rx_lvl_r <= 1'b1;
      rx_prev_r <= 1'b1;
    end else begin
      sync_r <= {sync_r[1:0], rxd};
      if (sync_r[1] == sync_r[2]) begin
        rx_lvl_r <= sync_r[2];
      end
      rx_prev_r <= rx_lvl_r;
    end
  end

  // Bit period is 2*(div+1) ticks; mid-bit is div+1 ticks.
  assign full_cnt = {div_r, 1'b0} + 8'h01;
  assign half_cnt = {1'b0, div_r};
  assign done = (st_r == UBR_STOPB) && mck_tick && bit_cnt_r == 8'h00;
  assign bad_stop = !rx_lvl_r;
  assign bad_par = mode_r[UBR_PAR_BIT] && (par_r != 1'b0);

  always_ff @(posedge clk) begin
    if (rst || !en_r) begin
      st_r <= UBR_IDLE;
      bit_cnt_r <= 8'h00;
      nbit_r <= 4'h0;
      shf_r <= 9'h000;
      par_r <= 1'b0;
    end else begin
      case (st_r)
        UBR_IDLE: begin
          if (rx_prev_r && !rx_lvl_r) begin
            st_r <= UBR_START;
            bit_cnt_r <= half_cnt;
          end
        end
        UBR_START: begin
          if (mck_tick) begin
            if (bit_cnt_r != 8'h00) begin
              bit_cnt_r <= bit_cnt_r - 8'h01;
            end else if (rx_lvl_r) begin
              st_r <= UBR_IDLE;
            end else begin
              st_r <= UBR_DATA;
              bit_cnt_r <= full_cnt;
              nbit_r <= 4'h0;
              par_r <= 1'b0;
            end
          end
        end
        UBR_DATA: begin
          if (mck_tick) begin
            if (bit_cnt_r != 8'h00) begin
              bit_cnt_r <= bit_cnt_r - 8'h01;
            end else begin
              shf_r <= {rx_lvl_r, shf_r[8:1]};
              par_r <= par_r ^ rx_lvl_r;
              bit_cnt_r <= full_cnt;
              nbit_r <= nbit_r + 4'h1;
              if (nbit_r == 4'(UBR_DATA_BITS - 1 + int'(mode_r[UBR_PAR_BIT])))
              begin
                st_r <= UBR_STOPB;
              end
            end
          end
        end
        UBR_STOPB: begin
          if (mck_tick) begin
            if (bit_cnt_r != 8'h00) begin
              bit_cnt_r <= bit_cnt_r - 8'h01;
            end else begin
              st_r <= UBR_IDLE;
            end
          end
        end
        default: st_r <= UBR_IDLE;
      endcase
    end
  end

  // Set wins over clear; a read clears only the full buffer it returned.
  always_ff @(posedge clk) begin
    if (rst) begin
      rxdat_r <= 8'h00;
      bff_r <= 1'b0;
      err_r <= '0;
    end else begin
      if (done && !bff_r) begin
        rxdat_r <= mode_r[UBR_PAR_BIT] ? shf_r[7:0] : shf_r[8:1];
      end
      if (done) begin
        bff_r <= 1'b1;
      end else if (rd && paddr == UBR_DATA_OFS && rd_full_r) begin
        bff_r <= 1'b0;
      end
      if (done && bff_r) begin
        err_r.ov <= 1'b1;
      end else if (wr && paddr == UBR_CLR_OFS && pwdata[UBR_OVF_BIT]) begin
        err_r.ov <= 1'b0;
      end
      if (done && bad_par) begin
        err_r.pe <= 1'b1;
      end else if (wr && paddr == UBR_CLR_OFS && pwdata[UBR_PEF_BIT]) begin
        err_r.pe <= 1'b0;
      end
      if (done && bad_stop) begin
        err_r.fe <= 1'b1;
      end else if (wr && paddr == UBR_CLR_OFS && pwdata[UBR_FEF_BIT]) begin
        err_r.fe <= 1'b0;
      end
    end
  end
  assign err_flags = err_r;

  a_stop_clears_en: assert property (@(posedge clk) disable iff (rst)
    wr && paddr == UBR_STOP_OFS && pwdata[0] |=> !en_r)
    else $error("stop write did not clear enable");
  a_start_sets_en: assert property (@(posedge clk) disable iff (rst)
    wr && paddr == UBR_START_OFS && pwdata[0] |=> en_r)
    else $error("start write did not set enable");
  a_read_clears_bff: assert property (@(posedge clk) disable iff (rst)
    rd && paddr == UBR_DATA_OFS && rd_full_r && !done |=> !bff_r)
    else $error("data read did not clear buffer full");
  a_clear_fe_flag: assert property (@(posedge clk) disable iff (rst)
    wr && paddr == UBR_CLR_OFS && pwdata[UBR_FEF_BIT] && !done
    |=> !err_r.fe)
    else $error("framing flag not cleared");
  a_overrun_sets: assert property (@(posedge clk) disable iff (rst)
    done && bff_r |=> err_r.ov && bff_r)
    else $error("overrun not flagged");
  a_stopped_idle: assert property (@(posedge clk) disable iff (rst)
    !en_r |=> st_r == UBR_IDLE)
    else $error("receiver ran while stopped");
  a_tick_selects: assert property (@(posedge clk) disable iff (rst)
    p_sel == 4'h0 |-> mck_tick)
    else $error("undivided prescaler missed a tick");
  sequence s_start_mid;
    st_r == UBR_START && mck_tick && bit_cnt_r == 8'h00 && en_r;
  endsequence
  a_bit_reload: assert property (@(posedge clk) disable iff (rst)
    s_start_mid ##0 !rx_lvl_r |=> bit_cnt_r == full_cnt)
    else $error("bit period reload wrong");
  a_enter_data: assert property (@(posedge clk) disable iff (rst)
    s_start_mid ##0 !rx_lvl_r |=> st_r == UBR_DATA)
    else $error("start bit did not lead to data");
endmodule : ubr_uart_rx

// ### tb/ubr_remote_tx.sv
// Model of the remote asynchronous transmitter on the receive pin.
// Assumes the bench gives the bit length in system clock cycles.
`timescale 1ns/10ps
module ubr_remote_tx (
  input wire logic clk, // System clock.
  input wire logic [15:0] bit_cyc, // Bit length in clock cycles.
  output logic rxd // Serial line towards the receiver.
);
  initial rxd = 1'b1;
  // Sends one frame LSB first, optionally with even parity or bad stop.
  task automatic send(input logic [7:0] d, input logic par_on,
      input logic bad_par, input logic bad_stop);
    logic [10:0] bits;
    int n;
    bits = {~bad_stop, (^d) ^ bad_par, d, 1'b0};
    n = par_on ? 11 : 10;
    if (!par_on) bits[9] = ~bad_stop;
    for (int i = 0; i < n; i++) begin
      rxd <= bits[i];
      repeat (bit_cyc) @(posedge clk);
    end
    rxd <= 1'b1;
  endtask : send
endmodule : ubr_remote_tx

// ### tb/ubr_uart_rx_tb.sv
// Self-checking bench of the UART baud and error block.
// Assumes the remote transmitter model and an APB master task.
`timescale 1ns/10ps
module ubr_uart_rx_tb;
  import ubr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rxd;
  ubr_err_t err_flags;
  logic enabled;
  logic [15:0] bit_cyc = 16'h000C;
  logic [31:0] rd;
  logic err_seen;
  int failures = 0;
  int compares = 0;
  always #5 clk = ~clk;
  ubr_uart_rx dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .err_flags(err_flags),
    .enabled(enabled));
  ubr_remote_tx remote (.clk(clk), .bit_cyc(bit_cyc), .rxd(rxd));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Read data is taken at the edge that samples pready high.
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
    if (n == 50) begin
      failures++;
      wrap_up();
    end
    err_seen = pslverr;
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr
  task automatic rdm(input logic [11:0] a, input logic [31:0] m,
      input logic [31:0] e);
    apb(1'b0, a, 32'h0, rd);
    chk(rd & m, e);
  endtask : rdm
  task automatic frame(input logic [7:0] d, input logic p, input logic bp,
      input logic bs);
    remote.send(d, p, bp, bs);
    repeat (2 * bit_cyc) @(posedge clk);
  endtask : frame
  task automatic t_reset();
    rdm(UBR_MODE_OFS, 32'hFFFF, 32'h0);
    rdm(UBR_PRESC_OFS, 32'hFF, 32'h0);
    rdm(UBR_DATA_OFS, 32'hFE00, 32'hFE00);
    rdm(UBR_ENST_OFS, 32'h1, 32'h0);
  endtask : t_reset
  task automatic t_rate();
    wr(UBR_DATA_OFS, 32'h0400);
    wr(UBR_PRESC_OFS, 32'h01);
    wr(UBR_START_OFS, 32'h1);
    chk({31'h0, enabled}, 32'h1);
    bit_cyc = 16'd12;
    frame(8'hA5, 1'b0, 1'b0, 1'b0);
    rdm(UBR_STAT_OFS, 32'h47, 32'h40);
    rdm(UBR_DATA_OFS, 32'hFEFF, 32'h04A5);
    rdm(UBR_STAT_OFS, 32'h47, 32'h0);
  endtask : t_rate
  task automatic t_clksel();
    wr(UBR_STOP_OFS, 32'h1);
    wr(UBR_MODE_OFS, 32'h8000);
    wr(UBR_PRESC_OFS, 32'h0F);
    wr(UBR_START_OFS, 32'h1);
    bit_cyc = 16'd6;
    frame(8'h3C, 1'b0, 1'b0, 1'b0);
    rdm(UBR_DATA_OFS, 32'hFF, 32'h3C);
    wr(UBR_STOP_OFS, 32'h1);
    wr(UBR_MODE_OFS, 32'h0001);
    wr(UBR_PRESC_OFS, 32'h01);
    wr(UBR_START_OFS, 32'h1);
    bit_cyc = 16'd12;
  endtask : t_clksel
  task automatic t_errors();
    frame(8'h5A, 1'b1, 1'b1, 1'b0);
    rdm(UBR_DATA_OFS, 32'hFF, 32'h5A);
    frame(8'h11, 1'b1, 1'b0, 1'b0);
    frame(8'h22, 1'b1, 1'b0, 1'b0);
    rdm(UBR_STAT_OFS, 32'h47, 32'h43);
    chk({29'h0, err_flags}, 32'h5);
    wr(UBR_CLR_OFS, rd);
    rdm(UBR_STAT_OFS, 32'h47, 32'h40);
    rdm(UBR_DATA_OFS, 32'hFF, 32'h11);
    wr(UBR_MODE_OFS, 32'h0);
  endtask : t_errors
  task automatic t_framing();
    frame(8'h66, 1'b0, 1'b0, 1'b1);
    rdm(UBR_STAT_OFS, 32'h47, 32'h44);
    rdm(UBR_DATA_OFS, 32'hFF, 32'h66);
    rdm(UBR_STAT_OFS, 32'h47, 32'h04);
    wr(UBR_CLR_OFS, rd);
    rdm(UBR_STAT_OFS, 32'h47, 32'h0);
    wr(UBR_STOP_OFS, 32'h1);
    rdm(UBR_ENST_OFS, 32'h1, 32'h0);
    frame(8'h77, 1'b0, 1'b0, 1'b0);
    rdm(UBR_STAT_OFS, 32'h47, 32'h0);
    wr(UBR_START_OFS, 32'h1);
    frame(8'h78, 1'b0, 1'b0, 1'b0);
    rdm(UBR_DATA_OFS, 32'hFF, 32'h78);
  endtask : t_framing
  task automatic t_unmapped();
    apb(1'b0, 12'h020, 32'h0, rd);
    chk({31'h0, err_seen}, 32'h1);
    chk(rd, UBR_BAD_ADDR_DATA);
  endtask : t_unmapped
  task automatic wrap_up();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_rate();
    t_clksel();
    t_errors();
    t_framing();
    t_unmapped();
    wrap_up();
  end
  initial begin
    #200000;
    failures++;
    wrap_up();
  end
endmodule : ubr_uart_rx_tb
